// ===== verilog/ebc_bus_ctrl.sv
// Our own choices: register access over Avalon-MM and the register offsets.
`default_nettype none
// Contract
// - In on-chip-only mode the control register ignores all writes.
// - Bus-disable bit clear: shared pins belong to the memory bus outside on-chip-only mode.
// - Bus-disable bit set: pins are I/O except during external access; for table ops the code moves pins one cycle late, still I/O at the strobe.
// - Bus-disable bit resets to zero, bus owns pins.
// - Wait code 11/10/01/00 adds 0/1/2/3 cycles to table ops.
// - Write mode selects 16-bit table write form; ignored at 8-bit.
// - Word mode: both latch bytes out, high strobe on second byte.
// - Wait states only apply when wait-enable configuration is set.
// - Bus-width configuration set selects 16-bit data bus.
// - Internal-only fetch: pins are I/O whatever the bus-disable bit holds.
module ebc_bus_ctrl
  import ebc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic onchip_only_mode,
  input wire logic wait_enable_cfg,
  input wire logic bus_width_config,
  input wire logic ext_access_req,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pins_to_bus,
  output logic [15:0] data_out,
  output logic high_byte_write_strobe,
  output logic low_byte_write_strobe,
  output logic table_busy
);
  // ==========================================================
  // Configuration inputs from pins/fuses pass two flops
  logic [2:0] cfg_meta_reg;
  logic [2:0] cfg_sync_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic onchip;
  logic wait_en;
  logic bw16;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_meta_reg <= 3'h4;
      cfg_sync_reg <= 3'h4;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else if (clk_en) begin
      cfg_meta_reg <= {bus_width_config, wait_enable_cfg, onchip_only_mode};
      cfg_sync_reg <= cfg_meta_reg;
      ext_meta_reg <= ext_access_req;
      ext_sync_reg <= ext_meta_reg;
    end
  end
  assign onchip = cfg_sync_reg[0];
  assign wait_en = cfg_sync_reg[1];
  assign bw16 = cfg_sync_reg[2];

  // ==========================================================
  // Registers and bus slave state
  ebc_state_t state_reg;
  ebc_state_t state_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] latch_low_reg;
  logic [7:0] latch_low_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wreq_reg;
  logic wreq_next;
  logic pins_reg;
  logic pins_next;
  logic [15:0] dout_reg;
  logic [15:0] dout_next;
  logic hstrobe_reg;
  logic hstrobe_next;
  logic lstrobe_reg;
  logic lstrobe_next;
  logic tbusy_reg;
  logic tbusy_next;
  logic start;
  logic timer_busy;
  logic bus_active;
  logic [1:0] wm;
  logic [7:0] wbyte;
  logic whigh;
  logic wgo;

  assign wm = ctrl_reg[EBC_WM_HI:EBC_WM_LO];
  assign wbyte = avs_writedata[7:0];
  assign whigh = avs_writedata[EBC_TW_HIGH_BIT];
  assign wgo = avs_writedata[EBC_TW_GO_BIT];
  assign bus_active = state_reg != EBC_IDLE;

  ebc_wait_timer u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(start),
    .wait_enable(wait_en),
    .wait_count_field(ctrl_reg[EBC_WAIT_HI:EBC_WAIT_LO]),
    .busy(timer_busy)
  );

  // Slave answers one cycle after request; table write holds off to end
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    latch_low_next = latch_low_reg;
    rdata_next = rdata_reg;
    wreq_next = 1'b1;
    dout_next = dout_reg;
    hstrobe_next = 1'b0;
    lstrobe_next = 1'b0;
    start = 1'b0;
    case (state_reg)
      EBC_IDLE: begin
        if ((avs_read || avs_write) && wreq_reg) begin
          if (avs_write && avs_address == EBC_TBLW_OFS) begin
            start = 1'b1;
            state_next = EBC_WAIT;
            if (bw16 && wm[1]) begin
              // Word mode: hold low byte, emit word on high byte
              if (!whigh) begin
                latch_low_next = wbyte;
              end else begin
                dout_next = {wbyte, latch_low_reg};
                hstrobe_next = 1'b1;
              end
            end else begin
              // Byte mode or 8-bit bus: byte copied to both halves
              dout_next = {wbyte, wbyte};
              hstrobe_next = bw16 && whigh && wgo;
              lstrobe_next = !(bw16 && whigh) && wgo;
            end
          end else begin
            wreq_next = 1'b0;
            if (avs_write && avs_address == EBC_CTRL_OFS && !onchip) begin
              ctrl_next = wbyte & EBC_CTRL_MASK;
            end
            case (avs_address)
              EBC_CTRL_OFS: rdata_next = {24'h000000, ctrl_reg};
              EBC_STAT_OFS: rdata_next = {27'h0, pins_reg, timer_busy,
                bw16, wait_en, onchip};
              EBC_TBLR_OFS: rdata_next = {16'h0000, dout_reg};
              default: rdata_next = 32'h00000000;
            endcase
          end
        end
      end
      EBC_WAIT: begin
        if (!start && !timer_busy) begin
          state_next = EBC_DONE;
          wreq_next = 1'b0;
        end
      end
      EBC_DONE: begin
        state_next = EBC_IDLE;
      end
      default: state_next = EBC_IDLE;
    endcase
    if (onchip) begin
      pins_next = 1'b0;
    end else if (!ctrl_reg[EBC_DIS_BIT]) begin
      pins_next = 1'b1;
    end else begin
      pins_next = ext_sync_reg || bus_active;
    end
    // Busy registered so the output comes straight from a flop
    tbusy_next = state_next != EBC_IDLE;
  end

  // Control register reset to zero keeps bus owning the pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= EBC_IDLE;
      ctrl_reg <= EBC_CTRL_RST;
      latch_low_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
      wreq_reg <= 1'b1;
      pins_reg <= 1'b1;
      dout_reg <= 16'h0000;
      hstrobe_reg <= 1'b0;
      lstrobe_reg <= 1'b0;
      tbusy_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      latch_low_reg <= latch_low_next;
      rdata_reg <= rdata_next;
      wreq_reg <= wreq_next;
      pins_reg <= pins_next;
      dout_reg <= dout_next;
      hstrobe_reg <= hstrobe_next;
      lstrobe_reg <= lstrobe_next;
      tbusy_reg <= tbusy_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wreq_reg;
  assign pins_to_bus = pins_reg;
  assign data_out = dout_reg;
  assign high_byte_write_strobe = hstrobe_reg;
  assign low_byte_write_strobe = lstrobe_reg;
  assign table_busy = tbusy_reg;

  // ==========================================================
  // Checks
  a_ctrl_locked: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && onchip) |=> $stable(ctrl_reg))
    else $error("control changed in on-chip mode");
  a_bus_owns: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && !onchip && !ctrl_reg[EBC_DIS_BIT]) |=> pins_to_bus)
    else $error("pins not given to bus");
  a_override: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && !onchip && ext_sync_reg) |=> pins_to_bus)
    else $error("bus did not override pins");
  a_io_idle: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && !onchip && ctrl_reg[EBC_DIS_BIT] && !ext_sync_reg
     && !bus_active) |=> !pins_to_bus)
    else $error("pins not released to I/O");
  a_word_out: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && state_reg == EBC_IDLE && wreq_reg && avs_write
     && avs_address == EBC_TBLW_OFS && bw16 && wm[1] && whigh)
    |=> high_byte_write_strobe && !low_byte_write_strobe
        && data_out[7:0] == $past(latch_low_reg))
    else $error("word write wrong");
  a_byte_copy: assert property (@(posedge sys_clk) disable iff (reset)
    (low_byte_write_strobe || (high_byte_write_strobe && !wm[1]))
    |-> data_out[15:8] == data_out[7:0])
    else $error("byte not copied");
  a_one_strobe: assert property (@(posedge sys_clk) disable iff (reset)
    !(high_byte_write_strobe && low_byte_write_strobe))
    else $error("both strobes active");
  a_narrow_bus: assert property (@(posedge sys_clk) disable iff (reset)
    !bw16 |-> !high_byte_write_strobe)
    else $error("high strobe on 8-bit bus");
endmodule : ebc_bus_ctrl
`default_nettype wire

// ===== verilog/ebc_pkg.sv
`default_nettype none
package ebc_pkg;
  // ==========================================================
  // Register map (word aligned, 32-bit Avalon data)
  localparam logic [3:0] EBC_CTRL_OFS = 4'h0;
  localparam logic [3:0] EBC_STAT_OFS = 4'h4;
  localparam logic [3:0] EBC_TBLW_OFS = 4'h8;
  localparam logic [3:0] EBC_TBLR_OFS = 4'hC;
  // ==========================================================
  // Control register fields
  localparam int EBC_DIS_BIT = 7;
  localparam int EBC_WAIT_HI = 5;
  localparam int EBC_WAIT_LO = 4;
  localparam int EBC_WM_HI = 1;
  localparam int EBC_WM_LO = 0;
  localparam logic [7:0] EBC_CTRL_RST = 8'h00;
  localparam logic [7:0] EBC_CTRL_MASK = 8'hB3;
  // ==========================================================
  // Table write data register fields
  localparam int EBC_TW_HIGH_BIT = 8;
  localparam int EBC_TW_GO_BIT = 9;
  // ==========================================================
  // Write modes and wait code decoding
  localparam logic [1:0] EBC_WM_BYTE = 2'h0;
  localparam logic [1:0] EBC_WM_UNUSED = 2'h1;
  localparam logic [1:0] EBC_WAIT_MAX = 2'h3;
  typedef enum {
    EBC_IDLE,
    EBC_WAIT,
    EBC_DONE
  } ebc_state_t;
endpackage : ebc_pkg
`default_nettype wire

// ===== verilog/ebc_wait_timer.sv
`default_nettype none
module ebc_wait_timer
  import ebc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire logic wait_enable,
  input wire logic [1:0] wait_count_field,
  output logic busy
);
  // ==========================================================
  // Wait-state counter
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic busy_reg;
  logic busy_next;

  // Code 11 adds zero cycles, 00 adds three
  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    if (start) begin
      count_next = EBC_WAIT_MAX - wait_count_field;
      busy_next = wait_enable && (wait_count_field != EBC_WAIT_MAX);
    end else if (busy_reg) begin
      if (count_reg == 2'h1) begin
        busy_next = 1'b0;
      end
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= 2'h0;
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      count_reg <= count_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;

  a_wait_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && start && !wait_enable) |=> !busy)
    else $error("wait applied while disabled");
  a_wait_three: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && start && wait_enable && wait_count_field == 2'h0)
    ##1 clk_en[*3] |-> busy ##1 !busy)
    else $error("three cycle wait wrong");
endmodule : ebc_wait_timer
`default_nettype wire

// ===== verification/ebc_mem_model.sv
`default_nettype none
module ebc_mem_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] data_out,
  input wire logic high_byte_write_strobe,
  input wire logic low_byte_write_strobe,
  output logic [7:0] mem_high,
  output logic [7:0] mem_low,
  output logic [7:0] write_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Byte lanes
  // Each lane stores only on its own strobe, so a wrong strobe shows
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_high <= 8'h00;
      mem_low <= 8'h00;
      write_count <= 8'h00;
    end else begin
      if (high_byte_write_strobe) begin
        mem_high <= data_out[15:8];
      end
      if (low_byte_write_strobe) begin
        mem_low <= data_out[7:0];
      end
      write_count <= write_count + 8'(high_byte_write_strobe)
        + 8'(low_byte_write_strobe);
    end
  end
endmodule : ebc_mem_model
`default_nettype wire

// ===== verification/test_external_memory_bus_control.sv
`default_nettype none
module test_external_memory_bus_control
  import ebc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, clk_en, onchip_only_mode, wait_enable_cfg;
  logic bus_width_config, ext_access_req, avs_read, avs_write;
  logic avs_waitrequest, pins_to_bus, table_busy;
  logic high_byte_write_strobe, low_byte_write_strobe;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] data_out;
  logic [7:0] mem_high, mem_low, write_count;
  int failures, cmp_count, edges, busy_edges;
  // ==========================================================
  // Design and memory
  ebc_bus_ctrl ebc_bus_ctrl_inst (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .onchip_only_mode(onchip_only_mode),
    .wait_enable_cfg(wait_enable_cfg), .bus_width_config(bus_width_config),
    .ext_access_req(ext_access_req), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins_to_bus(pins_to_bus),
    .data_out(data_out), .high_byte_write_strobe(high_byte_write_strobe),
    .low_byte_write_strobe(low_byte_write_strobe), .table_busy(table_busy));
  ebc_mem_model ebc_mem_model_inst (.sys_clk(sys_clk), .reset(reset),
    .data_out(data_out), .high_byte_write_strobe(high_byte_write_strobe),
    .low_byte_write_strobe(low_byte_write_strobe), .mem_high(mem_high),
    .mem_low(mem_low), .write_count(write_count));
  // ==========================================================
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("compares %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Bus cycle held until waitrequest is seen low; bounded so a hang ends
  task automatic access(input logic wr, input logic [3:0] adr,
                        input logic [31:0] wd);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    edges = 0;
    busy_edges = 0;
    do begin
      @(posedge sys_clk);
      edges++;
      if (table_busy === 1'b1) busy_edges++;
      if (edges > 50) begin
        failures++;
        results();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge sys_clk);
  endtask : access
  // Config inputs pass a 2-flop sync, so give them time to land
  task automatic cfg(input logic oc, we, wide, er);
    @(posedge sys_clk);
    onchip_only_mode <= oc;
    wait_enable_cfg <= we;
    bus_width_config <= wide;
    ext_access_req <= er;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cfg
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    {onchip_only_mode, wait_enable_cfg, ext_access_req} = 3'h0;
    bus_width_config = 1'b1;
    {avs_read, avs_write} = 2'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    failures = 0;
    cmp_count = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    access(1'b0, EBC_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    check(32'(pins_to_bus), 32'h1);
    access(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    access(1'b1, EBC_CTRL_OFS, 32'hFF);
    access(1'b0, EBC_CTRL_OFS, 32'h0);
    check(rd, 32'hB3);
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    check(32'(pins_to_bus), 32'h0);
    cfg(1'b0, 1'b0, 1'b1, 1'b1);
    check(32'(pins_to_bus), 32'h1);
    access(1'b1, EBC_CTRL_OFS, 32'h33);
    cfg(1'b0, 1'b1, 1'b1, 1'b0);
    check(32'(pins_to_bus), 32'h1);
    $display("test pin ownership done");
    for (int c = 0; c < 4; c++) begin
      access(1'b1, EBC_CTRL_OFS, 32'(c) << 4);
      access(1'b1, EBC_TBLW_OFS, 32'h11);
      check(32'(edges), 32'(6 - c));
      check(32'(busy_edges), 32'(5 - c));
    end
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    access(1'b1, EBC_CTRL_OFS, 32'h00);
    access(1'b1, EBC_TBLW_OFS, 32'h11);
    check(32'(edges), 32'h3);
    $display("test wait states done");
    access(1'b1, EBC_CTRL_OFS, 32'h30);
    access(1'b1, EBC_TBLW_OFS, 32'h3A5);
    check(32'(data_out), 32'hA5A5);
    check(32'({mem_high, write_count}), 32'hA501);
    access(1'b1, EBC_CTRL_OFS, 32'h31);
    access(1'b1, EBC_TBLW_OFS, 32'h25A);
    check(32'({mem_low, write_count}), 32'h5A02);
    for (int m = 2; m < 4; m++) begin
      access(1'b1, EBC_CTRL_OFS, 32'h30 | 32'(m));
      access(1'b1, EBC_TBLW_OFS, 32'h034);
      check(32'(write_count), 32'(m));
      access(1'b1, EBC_TBLW_OFS, 32'h112);
      check(32'(data_out), 32'h1234);
      check(32'({mem_high, write_count}), 32'h1200 | 32'(m + 1));
    end
    $display("test write modes done");
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    access(1'b1, EBC_CTRL_OFS, 32'h32);
    access(1'b1, EBC_TBLW_OFS, 32'h3C3);
    check(32'(data_out), 32'hC3C3);
    check(32'({mem_high, mem_low}), 32'h12C3);
    access(1'b0, EBC_STAT_OFS, 32'h0);
    check(32'(rd[2]), 32'h0);
    $display("test narrow bus done");
    @(posedge sys_clk);
    clk_en <= 1'b0;
    cfg(1'b1, 1'b0, 1'b1, 1'b0);
    check(32'(pins_to_bus), 32'h1);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    cfg(1'b1, 1'b0, 1'b1, 1'b0);
    check(32'(pins_to_bus), 32'h0);
    access(1'b1, EBC_CTRL_OFS, 32'h81);
    access(1'b0, EBC_CTRL_OFS, 32'h0);
    check(rd, 32'h32);
    $display("test on-chip mode done");
    results();
  end
endmodule : test_external_memory_bus_control
`default_nettype wire
